// ==== hdl/phase_osc_pkg.sv ====
/*
  Constants for the phase-shift and oscillator-select register slice.
  Assumes a byte-wide register port fed by the serial configuration front end.
*/
// What this block does
// - Synth 0 divider D quadrature field, bits 15:13, rotates its clocks in 45 degree steps.
// - Quadrature code 000 none, 001-011 minus 45-135, 100 180, 101-111 plus 135-45.
// - Oscillator select bit 0 clear enables driver, set disables; register resets to zero.
// - A fixed eight-bit secondary revision byte is readable alongside the main revision.
// - Synth 1 divider C coarse field, 13-bit two's complement, shifts by whole periods.
// - Negative coarse value delays the clock, positive value advances it, by that many periods.
// - Synth 1 divider C quadrature field, bits 15:13, rotates its clocks in 45 degree steps.
// - Synth 1 divider D coarse field, 13-bit two's complement, shifts by whole periods.
// - Each 16-bit phase register spans two byte addresses, resets to zero, reads and writes.
// - Synth 1 divider D register also holds a quadrature field in bits 15:13.
package phase_osc_pkg;
  localparam logic [7:0]  PH_S0_D_ADDR   = 8'hc1;
  localparam logic [7:0]  OSC_SEL_ADDR   = 8'hc3;
  localparam logic [7:0]  REV2_ADDR      = 8'hc6;
  localparam logic [7:0]  PH_S1_C_ADDR   = 8'hc7;
  localparam logic [7:0]  PH_S1_D_ADDR   = 8'hc9;
  localparam logic [15:0] PHASE_RESET    = 16'h0000;
  localparam logic [7:0]  OSC_SEL_RESET  = 8'h00;
  localparam int          OSC_SEL_BIT    = 0;
  localparam int          COARSE_MSB     = 12;
  localparam int          QUAD_LSB       = 13;
  localparam int          QUAD_MSB       = 15;
  // Arbitrary neutral value, not tied to any real silicon.
  localparam logic [7:0]  REV2_VALUE     = 8'h5a;
endpackage

// ==== hdl/phase_reg_pair.sv ====
/*
  One 16-bit phase register held as two bytes with a committed copy.
  Assumes one-cycle write strobes from the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_reg_pair
  import phase_osc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wdata,
  output logic      [15:0] host_q,
  output logic      [15:0] active_q
);
  // The low byte waits in the host copy; the high byte write commits both.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_q   <= PHASE_RESET;
      active_q <= PHASE_RESET;
    end else begin
      if (wr_lo) begin
        host_q[7:0] <= wdata;
      end
      if (wr_hi) begin
        host_q[15:8] <= wdata;
        active_q     <= {wdata, host_q[7:0]};
      end
    end
  end
endmodule // phase_reg_pair
`default_nettype wire

// ==== hdl/phase_osc_regs.sv ====
/*
  Phase-shift, quadrature and oscillator-select configuration registers.
  Assumes the serial front end presents byte reads and writes synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_osc_regs
  import phase_osc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  output logic      [7:0]        cfg_rdata,
  output logic      [12:0]       coarse_phase_synth0_div_d,
  output logic      [2:0]        quadrature_rot_synth0_div_d,
  output logic      [12:0]       coarse_phase_synth1_div_c,
  output logic      [2:0]        quadrature_rot_synth1_div_c,
  output logic      [12:0]       coarse_phase_synth1_div_d,
  output logic      [2:0]        quadrature_rot_synth1_div_d,
  output logic      [3:0]        quad_steps_synth0_div_d,
  output logic      [3:0]        quad_steps_synth1_div_c,
  output logic      [3:0]        quad_steps_synth1_div_d,
  output logic      [2:0]        coarse_advance,
  output logic      [2:0]        coarse_delay,
  output logic                   osc_output_driver_en
);
  // Signed 45 degree step count: positive advances, 4 means 180 degrees.
  function automatic logic [3:0] quad_steps(input logic [2:0] code);
    unique case (code)
      3'h0: quad_steps = 4'h0;
      3'h1: quad_steps = 4'hf;
      3'h2: quad_steps = 4'he;
      3'h3: quad_steps = 4'hd;
      3'h4: quad_steps = 4'h4;
      3'h5: quad_steps = 4'h3;
      3'h6: quad_steps = 4'h2;
      3'h7: quad_steps = 4'h1;
    endcase
  endfunction

  localparam logic [7:0] PH_BASE [3] = '{PH_S0_D_ADDR, PH_S1_C_ADDR, PH_S1_D_ADDR};

  logic [15:0] host_w   [3];
  logic [15:0] active_w [3];
  logic [7:0]  osc_sel_q;
  logic [7:0]  rdata_d;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      wire wr_lo_w = cfg_wr && (cfg_addr == PH_BASE[g]);
      wire wr_hi_w = cfg_wr && (cfg_addr == PH_BASE[g] + 8'h01);
      phase_reg_pair u_pair (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .wr_lo    (wr_lo_w),
        .wr_hi    (wr_hi_w),
        .wdata    (cfg_wdata),
        .host_q   (host_w[g]),
        .active_q (active_w[g])
      );
      wire signed [12:0] coarse_w = active_w[g][COARSE_MSB:0];
      assign coarse_delay[g]   = coarse_w < 0;
      assign coarse_advance[g] = coarse_w > 0;
    end
  endgenerate

  assign coarse_phase_synth0_div_d   = active_w[0][COARSE_MSB:0];
  assign quadrature_rot_synth0_div_d = active_w[0][QUAD_MSB:QUAD_LSB];
  assign coarse_phase_synth1_div_c   = active_w[1][COARSE_MSB:0];
  assign quadrature_rot_synth1_div_c = active_w[1][QUAD_MSB:QUAD_LSB];
  assign coarse_phase_synth1_div_d   = active_w[2][COARSE_MSB:0];
  assign quadrature_rot_synth1_div_d = active_w[2][QUAD_MSB:QUAD_LSB];
  assign quad_steps_synth0_div_d = quad_steps(quadrature_rot_synth0_div_d);
  assign quad_steps_synth1_div_c = quad_steps(quadrature_rot_synth1_div_c);
  assign quad_steps_synth1_div_d = quad_steps(quadrature_rot_synth1_div_d);

  // Only bit 0 is stored; the reserved bits read as zero.
  wire osc_wr_w = cfg_wr && (cfg_addr == OSC_SEL_ADDR);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_sel_q <= OSC_SEL_RESET;
    end else if (osc_wr_w) begin
      osc_sel_q <= {7'h00, cfg_wdata[OSC_SEL_BIT]};
    end
  end
  // The host picks the value per master clock kind; the block just obeys it.
  assign osc_output_driver_en = ~osc_sel_q[OSC_SEL_BIT];

  // Writes to the revision byte are accepted and dropped, so it stays fixed.
  assign rdata_d =
      (cfg_addr == PH_S0_D_ADDR)         ? host_w[0][7:0]  :
      (cfg_addr == PH_S0_D_ADDR + 8'h01) ? host_w[0][15:8] :
      (cfg_addr == PH_S1_C_ADDR)         ? host_w[1][7:0]  :
      (cfg_addr == PH_S1_C_ADDR + 8'h01) ? host_w[1][15:8] :
      (cfg_addr == PH_S1_D_ADDR)         ? host_w[2][7:0]  :
      (cfg_addr == PH_S1_D_ADDR + 8'h01) ? host_w[2][15:8] :
      (cfg_addr == OSC_SEL_ADDR)         ? osc_sel_q       :
      (cfg_addr == REV2_ADDR)            ? REV2_VALUE      : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_lo_write(logic [7:0] a);
    cfg_wr && cfg_addr == a;
  endsequence
  sequence s_hi_write(logic [7:0] a);
    cfg_wr && cfg_addr == a + 8'h01;
  endsequence

  // A low byte followed at once by its high byte: the usual host order.
  sequence s_pair_write(logic [7:0] a);
    s_lo_write(a) ##1 s_hi_write(a);
  endsequence

  quad_s0d_a: assert property (s_hi_write(PH_S0_D_ADDR) |=>
    quadrature_rot_synth0_div_d == $past(cfg_wdata[7:5]))
    else $error("synth0 D quadrature not committed");
  quad_dec_a: assert property (quadrature_rot_synth1_div_c == 3'h4 |->
    quad_steps_synth1_div_c == 4'h4)
    else $error("quadrature decode wrong");
  osc_drv_a: assert property (osc_wr_w |=>
    osc_output_driver_en == !$past(cfg_wdata[0]) && osc_sel_q[7:1] == 7'h00)
    else $error("oscillator driver select wrong");
  rev_read_a: assert property (cfg_rd && cfg_addr == REV2_ADDR |=>
    cfg_rdata == REV2_VALUE)
    else $error("revision byte wrong");
  coarse_s1c_a: assert property (s_lo_write(PH_S1_C_ADDR) ##1 s_hi_write(PH_S1_C_ADDR) |=>
    coarse_phase_synth1_div_c == {$past(cfg_wdata[4:0]), $past(cfg_wdata, 2)})
    else $error("synth1 C coarse phase wrong");
  coarse_dir_a: assert property (coarse_phase_synth1_div_d[12] |->
    coarse_delay[2] && !coarse_advance[2])
    else $error("coarse direction wrong");
  quad_s1c_a: assert property (s_hi_write(PH_S1_C_ADDR) |=>
    quadrature_rot_synth1_div_c == $past(cfg_wdata[7:5]))
    else $error("synth1 C quadrature not committed");
  rd_back_a: assert property (s_lo_write(PH_S1_D_ADDR) ##1 (cfg_rd && cfg_addr == PH_S1_D_ADDR &&
    !cfg_wr) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("phase byte read-back wrong");
  quad_s1d_a: assert property (s_hi_write(PH_S1_D_ADDR) |=>
    quadrature_rot_synth1_div_d == $past(cfg_wdata[7:5]))
    else $error("synth1 D quadrature not committed");
  half_hold_a: assert property (s_lo_write(PH_S0_D_ADDR) |=>
    $stable(coarse_phase_synth0_div_d))
    else $error("divider saw a half-written value");

  // Each step count is held against fixed constants, not against the decoder.
  quad_zero_a: assert property (quadrature_rot_synth1_div_d == 3'h0 |->
    quad_steps_synth1_div_d == 4'h0)
    else $error("zero quadrature code decoded wrong");

  quad_m45_a: assert property (quadrature_rot_synth0_div_d == 3'h1 |->
    quad_steps_synth0_div_d == 4'hf)
    else $error("minus 45 code decoded wrong");

  quad_m90_a: assert property (quadrature_rot_synth0_div_d == 3'h2 |->
    quad_steps_synth0_div_d == 4'he)
    else $error("minus 90 code decoded wrong");

  quad_m135_a: assert property (quadrature_rot_synth1_div_d == 3'h3 |->
    quad_steps_synth1_div_d == 4'hd)
    else $error("minus 135 code decoded wrong");

  quad_p135_a: assert property (quadrature_rot_synth1_div_c == 3'h5 |->
    quad_steps_synth1_div_c == 4'h3)
    else $error("plus 135 code decoded wrong");

  quad_p90_a: assert property (quadrature_rot_synth0_div_d == 3'h6 |->
    quad_steps_synth0_div_d == 4'h2)
    else $error("plus 90 code decoded wrong");

  quad_p45_a: assert property (quadrature_rot_synth0_div_d == 3'h7 |->
    quad_steps_synth0_div_d == 4'h1)
    else $error("plus 45 code decoded wrong");

  coarse_s0d_a: assert property (s_hi_write(PH_S0_D_ADDR) |=>
    coarse_phase_synth0_div_d == {$past(cfg_wdata[4:0]), $past(host_w[0][7:0])})
    else $error("synth0 D coarse phase wrong");

  coarse_s1d_a: assert property (s_pair_write(PH_S1_D_ADDR) |=>
    coarse_phase_synth1_div_d == {$past(cfg_wdata[4:0]), $past(cfg_wdata, 2)})
    else $error("synth1 D coarse phase wrong");

  adv_zero_a: assert property (coarse_phase_synth0_div_d == 13'h0000 |->
    !coarse_advance[0] && !coarse_delay[0])
    else $error("zero coarse value moved the clock");

  adv_pos_a: assert property (!coarse_phase_synth1_div_c[12] &&
    coarse_phase_synth1_div_c != 13'h0000 |-> coarse_advance[1] && !coarse_delay[1])
    else $error("positive coarse value did not advance");

  adv_neg_a: assert property (coarse_phase_synth0_div_d[12] |->
    coarse_delay[0] && !coarse_advance[0])
    else $error("negative coarse value did not delay");

  osc_hold_a: assert property (!osc_wr_w |=>
    $stable(osc_output_driver_en))
    else $error("driver select changed without a write");

  rd_hold_a: assert property (!cfg_rd |=>
    $stable(cfg_rdata))
    else $error("read data changed without a read");

  unmap_rd_a: assert property (cfg_rd && cfg_addr == 8'h50 |=>
    cfg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Outputs may only move on a high byte write, so the divider never tears.
  c_hold_a: assert property (!(cfg_wr && cfg_addr == PH_S1_C_ADDR + 8'h01) |=>
    $stable(coarse_phase_synth1_div_c) && $stable(quadrature_rot_synth1_div_c))
    else $error("synth1 C moved without a commit");

  d_hold_a: assert property (!(cfg_wr && cfg_addr == PH_S1_D_ADDR + 8'h01) |=>
    $stable(coarse_phase_synth1_div_d) && $stable(quadrature_rot_synth1_div_d))
    else $error("synth1 D moved without a commit");

  s0d_hold_a: assert property (!(cfg_wr && cfg_addr == PH_S0_D_ADDR + 8'h01) |=>
    $stable(quadrature_rot_synth0_div_d))
    else $error("synth0 D moved without a commit");
endmodule // phase_osc_regs
`default_nettype wire

// ==== verif/phase_osc_regs_tb_top.sv ====
/*
  Self-checking bench for the phase, quadrature and oscillator-select registers.
  Assumes the byte register port and the package constants as declared in hdl/.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_osc_regs_tb_top;
  import phase_osc_pkg::*;
  logic        ref_clk, rst_n, cfg_wr, cfg_rd;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
  logic [12:0] cp0d, cp1c, cp1d;
  logic [2:0]  qr0d, qr1c, qr1d, adv, dly;
  logic [3:0]  qs0d, qs1c, qs1d;
  logic        drv_en;
  int          bad_count, samples_checked, cycles;
  logic [3:0]  steps_exp [8] = '{4'h0, 4'hf, 4'he, 4'hd, 4'h4, 4'h3, 4'h2, 4'h1};

  phase_osc_regs phase_osc_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .coarse_phase_synth0_div_d(cp0d), .quadrature_rot_synth0_div_d(qr0d),
    .coarse_phase_synth1_div_c(cp1c), .quadrature_rot_synth1_div_c(qr1c),
    .coarse_phase_synth1_div_d(cp1d), .quadrature_rot_synth1_div_d(qr1d),
    .quad_steps_synth0_div_d(qs0d), .quad_steps_synth1_div_c(qs1c),
    .quad_steps_synth1_div_d(qs1d), .coarse_advance(adv), .coarse_delay(dly),
    .osc_output_driver_en(drv_en));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string name);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One strobe cycle per byte; the strobe drops on the next edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    check({8'h00, cfg_rdata}, {8'h00, exp}, name);
  endtask

  // Low byte write with a read of the same byte straight after it.
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input string name);
    @(posedge ref_clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    check({8'h00, cfg_rdata}, {8'h00, d}, name);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hang ends the run as a failure rather than stalling the simulator.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    check({15'h0000, drv_en}, 16'h0001, "driver enable after reset");
    check({3'h0, cp1c}, 16'h0000, "coarse s1c after reset");
    rdchk(PH_S1_D_ADDR + 8'h01, 8'h00, "s1d high reset");
    rdchk(OSC_SEL_ADDR, 8'h00, "osc select reset");
    rdchk(REV2_ADDR, REV2_VALUE, "revision");
    wr(REV2_ADDR, 8'h00);
    rdchk(REV2_ADDR, REV2_VALUE, "revision after write");
    wr(OSC_SEL_ADDR, 8'hff);
    check({15'h0000, drv_en}, 16'h0000, "driver off for oscillator");
    rdchk(OSC_SEL_ADDR, 8'h01, "osc select readback");
    wr(OSC_SEL_ADDR, 8'h00);
    check({15'h0000, drv_en}, 16'h0001, "driver on for crystal");
    rdchk(8'h50, 8'h00, "unmapped read");
    wr(PH_S1_C_ADDR, 8'h05);
    check({3'h0, cp1c}, 16'h0000, "s1c held after low byte");
    rdchk(PH_S1_C_ADDR, 8'h05, "s1c low host copy");
    wr(PH_S1_C_ADDR + 8'h01, 8'ha0);
    check({3'h0, cp1c}, 16'h0005, "s1c coarse");
    check({13'h0000, qr1c}, 16'h0005, "s1c quadrature");
    check({12'h000, qs1c}, 16'h0003, "s1c steps");
    check({14'h0000, adv[1], dly[1]}, 16'h0002, "s1c advance");
    wr(PH_S1_D_ADDR, 8'hff);
    wr(PH_S1_D_ADDR + 8'h01, 8'h7f);
    check({3'h0, cp1d}, 16'h1fff, "s1d coarse");
    check({13'h0000, qr1d}, 16'h0003, "s1d quadrature");
    check({14'h0000, adv[2], dly[2]}, 16'h0001, "s1d delay");
    check({12'h000, qs1d}, 16'h000d, "s1d steps");
    rdchk(PH_S1_D_ADDR + 8'h01, 8'h7f, "s1d high readback");
    wrrd(PH_S1_D_ADDR, 8'h3c, "s1d low back to back");
    check({3'h0, cp1d}, 16'h1fff, "s1d held after low byte");
    for (int i = 0; i < 8; i++) begin
      wr(PH_S0_D_ADDR, 8'h01);
      wr(PH_S0_D_ADDR + 8'h01, {i[2:0], 5'h00});
      check({13'h0000, qr0d}, {13'h0000, i[2:0]}, "s0d quadrature");
      check({12'h000, qs0d}, {12'h000, steps_exp[i]}, "s0d steps");
      check({3'h0, cp0d}, 16'h0001, "s0d coarse");
      check({14'h0000, adv[0], dly[0]}, 16'h0002, "s0d advance");
    end
    results();
  end
endmodule // phase_osc_regs_tb_top
`default_nettype wire
